/* design/cia_pkg.sv */
// Constants shared by the core interrupt aggregation block.
// Assumes an 8-bit memory-mapped register port from the embedded core.
package cia_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [15:0] SRC_FLAGS_ADDR = 16'h7F00;
  localparam logic [15:0] MASK_BITS_ADDR = 16'h7F01;
  localparam logic [7:0] SRC_FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASK_BITS_RESET = 8'h00;

  // ---------------------------------------------------------------------
  // Source bit positions
  // ---------------------------------------------------------------------
  localparam int BIT_CHAN_D = 7;
  localparam int BIT_CHAN_C = 6;
  localparam int BIT_CHAN_B = 5;
  localparam int BIT_CHAN_A = 4;
  localparam int BIT_BUS_TWO = 3;
  localparam int BIT_WAKE_FOUR = 2;
  localparam int BIT_WAKE_TWO = 1;
  localparam int BIT_WAKE_THREE = 0;

  // ---------------------------------------------------------------------
  // Core interrupt vectors, highest priority first
  // ---------------------------------------------------------------------
  localparam logic [7:0] VEC_POWER_FAIL = 8'h33;
  localparam logic [7:0] VEC_EXT_ZERO = 8'h03;
  localparam logic [7:0] VEC_EXT_ONE = 8'h13;
  localparam logic [7:0] VEC_WAKE = 8'h5B;
  localparam logic [7:0] VEC_NONE = 8'h00;

  // Priority level of an interrupt request.
  typedef enum logic [1:0] {
    LVL_LOW,
    LVL_HIGH,
    LVL_POWER_FAIL
  } cia_level_t;

  // Wake trigger kinds.
  typedef enum logic [1:0] {
    TRIG_FIXED,
    TRIG_SELECTABLE,
    TRIG_EITHER
  } cia_trig_t;

endpackage

/* design/cia_wake_detect.sv */
// Wake event detector for one pin.
// Assumes the pin level is synchronous to ref_clk_in.
module cia_wake_detect (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic pin_in,
  input wire cia_pkg::cia_trig_t trig_kind_in,
  input wire logic rise_sel_in,
  output logic event_out
);

  logic pin_prev;
  wire rise = pin_in & ~pin_prev;
  wire fall = ~pin_in & pin_prev;

  // -----------------------------------------------------------------------
  // Edge selection
  // -----------------------------------------------------------------------
  // The fixed kind uses the falling edge; selectable follows rise_sel_in.
  // Watching the raw pin keeps the wake alive whatever function it carries.
  wire next_event = (trig_kind_in == cia_pkg::TRIG_EITHER) ? (rise | fall) :
    (trig_kind_in == cia_pkg::TRIG_SELECTABLE) ?
    (rise_sel_in ? rise : fall) : fall;

  // Previous level and one-cycle event pulse.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_prev <= 1'b0;
      event_out <= 1'b0;
    end else begin
      pin_prev <= pin_in;
      event_out <= next_event;
    end
  end

endmodule

/* design/cia_prio_select.sv */
// Fixed-priority vector selection for the core's interrupt inputs.
// Assumes request levels are already gated by their enables.
module cia_prio_select (
  input wire logic pfi_req_in,
  input wire logic ext_zero_req_in,
  input wire logic ext_one_req_in,
  input wire logic wake_req_in,
  input wire logic [2:0] high_prio_in,
  output logic [7:0] vector_out,
  output cia_pkg::cia_level_t level_out,
  output logic any_out
);

  // Request and high flags packed in natural order: ext0, ext1, wake.
  wire [2:0] reqs = {wake_req_in, ext_one_req_in, ext_zero_req_in};
  wire [2:0] high_reqs = reqs & high_prio_in;
  wire [2:0] pick = (|high_reqs) ? high_reqs : reqs;

  // -----------------------------------------------------------------------
  // Selection
  // -----------------------------------------------------------------------
  // Power fail wins above both levels; inside a level natural order rules.
  assign vector_out = pfi_req_in ? cia_pkg::VEC_POWER_FAIL :
    pick[0] ? cia_pkg::VEC_EXT_ZERO :
    pick[1] ? cia_pkg::VEC_EXT_ONE :
    pick[2] ? cia_pkg::VEC_WAKE : cia_pkg::VEC_NONE;
  assign level_out = pfi_req_in ? cia_pkg::LVL_POWER_FAIL :
    (|high_reqs) ? cia_pkg::LVL_HIGH : cia_pkg::LVL_LOW;
  assign any_out = pfi_req_in | (|reqs);

endmodule

/* design/cia_core_irq.sv */
// Interrupt aggregation for the embedded core: external interrupt 0 source
// and mask registers, wake interrupt line and fixed vector selection.
// Assumes a synchronous 8-bit register port with one-cycle strobes.
//
// Notes on behaviour
// - Unmasked latched source bits are ORed onto the interrupt 0 line.
// - Writing one clears a source bit; writing zero leaves it unchanged.
// - Mask bit zero lets its source through; one blocks it.
// - Masked sources still latch and read back, but do not drive the interrupt 0 line.
// - Mask register is read/write and resets to all zeros.
// - Bits 7 and 6 take channels D and C only in channel port mode.
// - Bits 5 and 4 take channels B, A or legacy ports 2, 1.
// - Bit 3 reads one while the second bus controller requests.
// - Power fail, high and low levels; power fail beats everything.
// - Fixed natural priority with fixed vectors per interrupt.
// - Wake line gathers both wake groups and restarts a sleeping core.
// - Wake triggers are fixed edge, selectable edge or either edge.
// - Wake detection watches the pin, whatever function it carries.
module cia_core_irq (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic port_logic_select_in,
  input wire logic serial_chan_d_irq_in,
  input wire logic serial_chan_c_irq_in,
  input wire logic serial_chan_b_irq_in,
  input wire logic serial_chan_a_irq_in,
  input wire logic legacy_port_two_irq_in,
  input wire logic legacy_port_one_irq_in,
  input wire logic bus_two_irq_in,
  input wire logic wake_pin_four_in,
  input wire logic wake_pin_two_in,
  input wire logic wake_pin_three_in,
  input wire logic wake_group_one_in,
  input wire logic wake_group_two_in,
  input wire logic ext_irq_one_req_in,
  input wire logic pfi_req_in,
  input wire logic pfi_enable_in,
  input wire logic ext_zero_enable_in,
  input wire logic ext_one_enable_in,
  input wire logic wake_enable_in,
  input wire logic [2:0] high_prio_in,
  input wire logic core_sleeping_in,
  output logic [7:0] reg_rdata_out,
  output logic ext_irq_zero_line_n_out,
  output logic wake_irq_line_n_out,
  output logic core_restart_out,
  output logic irq_pending_out,
  output logic [7:0] irq_vector_out,
  output logic [1:0] irq_level_out
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  logic [7:0] src_flags;
  logic [7:0] mask_bits;
  logic ev_four, ev_two, ev_three;
  logic [7:0] sel_vector;
  cia_pkg::cia_level_t sel_level;
  logic sel_any;

  // Byte-wise decode shared by both registers.
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  wire src_wr = reg_wr_in & hit(reg_addr_in, cia_pkg::SRC_FLAGS_ADDR);
  wire mask_wr = reg_wr_in & hit(reg_addr_in, cia_pkg::MASK_BITS_ADDR);
  wire src_rd = reg_rd_in & hit(reg_addr_in, cia_pkg::SRC_FLAGS_ADDR);
  wire mask_rd = reg_rd_in & hit(reg_addr_in, cia_pkg::MASK_BITS_ADDR);

  // -----------------------------------------------------------------------
  // Wake pin edge detectors
  // -----------------------------------------------------------------------
  // All three either-edge pins use the either-edge trigger kind.
  cia_wake_detect u_wake_four (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(wake_pin_four_in),
    .trig_kind_in(cia_pkg::TRIG_EITHER),
    .rise_sel_in(1'b0),
    .event_out(ev_four)
  );
  cia_wake_detect u_wake_two (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(wake_pin_two_in),
    .trig_kind_in(cia_pkg::TRIG_EITHER),
    .rise_sel_in(1'b0),
    .event_out(ev_two)
  );
  cia_wake_detect u_wake_three (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(wake_pin_three_in),
    .trig_kind_in(cia_pkg::TRIG_EITHER),
    .rise_sel_in(1'b0),
    .event_out(ev_three)
  );

  // -----------------------------------------------------------------------
  // Source routing
  // -----------------------------------------------------------------------
  // Channels C and D only exist in channel mode; legacy logic has no twin.
  wire set_d = port_logic_select_in & serial_chan_d_irq_in;
  wire set_c = port_logic_select_in & serial_chan_c_irq_in;
  wire set_b = port_logic_select_in ? serial_chan_b_irq_in :
    legacy_port_two_irq_in;
  wire set_a = port_logic_select_in ? serial_chan_a_irq_in :
    legacy_port_one_irq_in;
  wire [7:0] set_vec = {set_d, set_c, set_b, set_a, bus_two_irq_in,
    ev_four, ev_two, ev_three};

  // Set beats clear so an event landing on the clear write is kept.
  wire [7:0] clr_vec = src_wr ? reg_wdata_in : 8'h00;
  wire [7:0] next_src_flags = (src_flags & ~clr_vec) | set_vec;
  wire [7:0] next_mask_bits = mask_wr ? reg_wdata_in : mask_bits;

  // Masked bits still latch above; only the line is gated here.
  wire [7:0] live = src_flags & ~mask_bits;
  wire next_zero_req = |live;
  wire next_wake_req = wake_group_one_in | wake_group_two_in |
    (|{ev_four, ev_two, ev_three});

  wire [7:0] next_rdata = src_rd ? src_flags :
    mask_rd ? mask_bits : 8'h00;

  // -----------------------------------------------------------------------
  // Priority selection
  // -----------------------------------------------------------------------
  cia_prio_select u_prio (
    .pfi_req_in(pfi_req_in & pfi_enable_in),
    .ext_zero_req_in(~ext_irq_zero_line_n_out & ext_zero_enable_in),
    .ext_one_req_in(ext_irq_one_req_in & ext_one_enable_in),
    .wake_req_in(~wake_irq_line_n_out & wake_enable_in),
    .high_prio_in(high_prio_in),
    .vector_out(sel_vector),
    .level_out(sel_level),
    .any_out(sel_any)
  );

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  // Source and mask registers; mask starts open.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_flags <= cia_pkg::SRC_FLAGS_RESET;
      mask_bits <= cia_pkg::MASK_BITS_RESET;
    end else begin
      src_flags <= next_src_flags;
      mask_bits <= next_mask_bits;
    end
  end

  // Registered outputs; the lines are active low toward the core.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
      ext_irq_zero_line_n_out <= 1'b1;
      wake_irq_line_n_out <= 1'b1;
      core_restart_out <= 1'b0;
      irq_pending_out <= 1'b0;
      irq_vector_out <= cia_pkg::VEC_NONE;
      irq_level_out <= 2'h0;
    end else begin
      reg_rdata_out <= next_rdata;
      ext_irq_zero_line_n_out <= ~next_zero_req;
      wake_irq_line_n_out <= ~next_wake_req;
      core_restart_out <= core_sleeping_in & next_wake_req;
      irq_pending_out <= sel_any;
      irq_vector_out <= sel_vector;
      irq_level_out <= sel_level;
    end
  end

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  line_follows_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    ext_irq_zero_line_n_out == ~$past(|(src_flags & ~mask_bits)))
    else $error("Interrupt 0 line does not follow unmasked sources.");

  clear_one_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (src_wr && reg_wdata_in[0] && !ev_three) |=> !src_flags[0])
    else $error("Source bit 0 not cleared by a one write.");

  mask_blocks_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (mask_bits == 8'hFF) |=> ext_irq_zero_line_n_out)
    else $error("Fully masked sources still raise the line.");

  masked_latch_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    bus_two_irq_in |=> src_flags[cia_pkg::BIT_BUS_TWO])
    else $error("Bus source not latched.");

  mask_write_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    mask_wr |=> mask_bits == $past(reg_wdata_in))
    else $error("Mask write not stored.");

  chan_d_gate_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (!port_logic_select_in && !src_flags[7]) |=> !src_flags[7])
    else $error("Channel D bit set in legacy mode.");

  set_wins_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (src_wr && reg_wdata_in[3] && bus_two_irq_in) |=> src_flags[3])
    else $error("Clear overrode a simultaneous set.");

  wake_restart_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (core_sleeping_in && (wake_group_one_in || wake_group_two_in)) |=>
    core_restart_out)
    else $error("Wake did not restart the sleeping core.");

  restart_idle_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !core_sleeping_in |=> !core_restart_out)
    else $error("Restart raised for a core that is awake.");

  wake_line_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (wake_group_one_in || wake_group_two_in) |=> !wake_irq_line_n_out)
    else $error("Wake group did not pull the wake line.");

  wake_pin_latch_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    ev_four |=> src_flags[cia_pkg::BIT_WAKE_FOUR])
    else $error("Wake pin event not latched.");

  wake_pin_line_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (ev_two || ev_three) |=> !wake_irq_line_n_out)
    else $error("Wake pin event did not reach the wake line.");

  chan_c_gate_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (!port_logic_select_in && !src_flags[6]) |=> !src_flags[6])
    else $error("Channel C bit set in legacy mode.");

  chan_b_route_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (port_logic_select_in && serial_chan_b_irq_in) |=> src_flags[5])
    else $error("Channel B event not latched in bit 5.");

  legacy_two_route_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (!port_logic_select_in && legacy_port_two_irq_in) |=> src_flags[5])
    else $error("Legacy port 2 event not latched in bit 5.");

  legacy_one_route_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (!port_logic_select_in && legacy_port_one_irq_in) |=> src_flags[4])
    else $error("Legacy port 1 event not latched in bit 4.");

  bus_readback_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (src_rd && src_flags[cia_pkg::BIT_BUS_TWO]) |=>
    reg_rdata_out[cia_pkg::BIT_BUS_TWO])
    else $error("Bus source bit does not read back as one.");

  zero_write_keeps_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (src_wr && !reg_wdata_in[3] && src_flags[3]) |=> src_flags[3])
    else $error("Writing zero cleared a source bit.");

  mask_hold_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !mask_wr |=> $stable(mask_bits))
    else $error("Mask changed without a write.");

  ext_zero_vector_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (!(pfi_req_in && pfi_enable_in) && !ext_irq_zero_line_n_out &&
    ext_zero_enable_in && (high_prio_in == 3'h0)) |=>
    irq_vector_out == cia_pkg::VEC_EXT_ZERO)
    else $error("Interrupt 0 did not win the low level.");

  idle_no_pending_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (!(pfi_req_in && pfi_enable_in) && ext_irq_zero_line_n_out &&
    wake_irq_line_n_out && !ext_irq_one_req_in) |=> !irq_pending_out)
    else $error("Pending shown with no request.");

  pfi_level_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (pfi_req_in && pfi_enable_in) |=>
    irq_level_out == cia_pkg::LVL_POWER_FAIL)
    else $error("Power fail level not reported.");

  pfi_first_a: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (pfi_req_in && pfi_enable_in) |=>
    irq_vector_out == cia_pkg::VEC_POWER_FAIL)
    else $error("Power fail vector not chosen first.");

endmodule

/* bench/cia_core_model.sv */
// Behavioural model of the embedded core's sleep and restart handling.
// Assumes restart requests arrive as registered levels on the core clock.
module cia_core_model #(
  parameter int WAKE_DELAY = 2
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic sleep_req_in,
  input wire logic core_restart_in,
  output logic core_sleeping_out,
  output logic [7:0] restart_count_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;

  // A slow core needs a few cycles to leave sleep once restart is seen.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      core_sleeping_out <= 1'b0;
      wait_cnt <= 0;
      restart_count_out <= 8'h00;
    end else if (sleep_req_in) begin
      core_sleeping_out <= 1'b1;
    end else if (core_sleeping_out &&
                 (core_restart_in || wait_cnt != 0)) begin
      if (wait_cnt == WAKE_DELAY) begin
        core_sleeping_out <= 1'b0;
        wait_cnt <= 0;
        restart_count_out <= restart_count_out + 8'h01;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule

/* bench/test_core_irq_aggregation.sv */
// Self-checking testbench for the core interrupt aggregation block.
// Assumes the package, the design and the core model are compiled first.
module test_core_irq_aggregation;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SRC = cia_pkg::SRC_FLAGS_ADDR;
  localparam logic [15:0] MSK = cia_pkg::MASK_BITS_ADDR;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sel = 1'b0;
  logic pf = 1'b0, e1 = 1'b0, slp = 1'b0, sleeping, l0_n, wk_n, restart, pend;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00, src = 8'h00, rdata, vec, rcount;
  logic [1:0] leg = 2'b00, grp = 2'b00, lvl;
  logic [2:0] wp = 3'b000, hp = 3'b000;
  logic [3:0] en = 4'hF;
  int bad_count = 0, total_checks = 0;

  // -------------------------------------------------------------------
  // Clock, design and core model
  // -------------------------------------------------------------------
  always #2.5 clk = ~clk;

  cia_core_irq u_dut (
    .ref_clk_in(clk),
    .reset_n_in(rst_n),
    .reg_addr_in(addr),
    .reg_wr_in(wr),
    .reg_rd_in(rd),
    .reg_wdata_in(wd),
    .port_logic_select_in(sel),
    .serial_chan_d_irq_in(src[7]),
    .serial_chan_c_irq_in(src[6]),
    .serial_chan_b_irq_in(src[5]),
    .serial_chan_a_irq_in(src[4]),
    .legacy_port_two_irq_in(leg[1]),
    .legacy_port_one_irq_in(leg[0]),
    .bus_two_irq_in(src[3]),
    .wake_pin_four_in(wp[2]),
    .wake_pin_two_in(wp[1]),
    .wake_pin_three_in(wp[0]),
    .wake_group_one_in(grp[0]),
    .wake_group_two_in(grp[1]),
    .ext_irq_one_req_in(e1),
    .pfi_req_in(pf),
    .pfi_enable_in(en[0]),
    .ext_zero_enable_in(en[1]),
    .ext_one_enable_in(en[2]),
    .wake_enable_in(en[3]),
    .high_prio_in(hp),
    .core_sleeping_in(sleeping),
    .reg_rdata_out(rdata),
    .ext_irq_zero_line_n_out(l0_n),
    .wake_irq_line_n_out(wk_n),
    .core_restart_out(restart),
    .irq_pending_out(pend),
    .irq_vector_out(vec),
    .irq_level_out(lvl)
  );

  cia_core_model u_core (
    .ref_clk_in(clk),
    .reset_n_in(rst_n),
    .sleep_req_in(slp),
    .core_restart_in(restart),
    .core_sleeping_out(sleeping),
    .restart_count_out(rcount)
  );

  // -------------------------------------------------------------------
  // Access and compare tasks
  // -------------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // The strobe is held over one sampling edge, then dropped.
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data is registered, so it is looked at just after the next edge.
  task automatic rreg(input logic [15:0] a, input logic [7:0] e,
                      input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask

  task automatic pls(input logic [7:0] s, input logic [1:0] l);
    @(posedge clk);
    src <= s;
    leg <= l;
    @(posedge clk);
    src <= 8'h00;
    leg <= 2'b00;
  endtask

  // Requests in r: bit 0 power fail, bit 1 ext one, bits 3:2 wake groups.
  task automatic prio(input logic [3:0] r, input logic [2:0] h,
                      input logic [7:0] v, input logic [1:0] l);
    @(posedge clk);
    pf <= r[0];
    e1 <= r[1];
    grp <= r[3:2];
    hp <= h;
    tick(4);
    chk("vector", v, vec);
    chk("level", {6'h00, l}, {6'h00, lvl});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------------
  // The watchdog allows over twenty times the expected run of some 180 cycles.
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    $display("MISMATCH watchdog expected done seen timeout");
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rreg(SRC, 8'h00, "src reset");
    rreg(MSK, 8'h00, "mask reset");
    wreg(MSK, 8'hA5);
    rreg(MSK, 8'hA5, "mask rw");
    rreg(16'h7F02, 8'h00, "unmapped");
    wreg(MSK, 8'h00);
    $display("test registers done");
    @(posedge clk) sel <= 1'b1;
    for (int i = 3; i < 8; i++) begin
      pls(8'h01 << i, 2'b00);
      tick(2);
      chk("line low", 8'h00, {7'h00, l0_n});
      chk("vector", cia_pkg::VEC_EXT_ZERO, vec);
      rreg(SRC, 8'h01 << i, "src bit");
      wreg(SRC, 8'h01 << i);
      rreg(SRC, 8'h00, "src clear");
      chk("line high", 8'h01, {7'h00, l0_n});
    end
    pls(8'h00, 2'b11);
    rreg(SRC, 8'h00, "legacy ignored");
    @(posedge clk) sel <= 1'b0;
    pls(8'hC0, 2'b11);
    rreg(SRC, 8'h30, "legacy mode");
    wreg(SRC, 8'h30);
    @(posedge clk) wp <= 3'b111;
    tick(3);
    rreg(SRC, 8'h07, "wake rise");
    wreg(SRC, 8'h07);
    @(posedge clk) wp <= 3'b000;
    tick(3);
    rreg(SRC, 8'h07, "wake fall");
    wreg(SRC, 8'h07);
    $display("test sources done");
    wreg(MSK, 8'hFF);
    pls(8'h08, 2'b00);
    tick(2);
    chk("masked line", 8'h01, {7'h00, l0_n});
    rreg(SRC, 8'h08, "masked src");
    wreg(SRC, 8'h00);
    rreg(SRC, 8'h08, "zero write");
    wreg(MSK, 8'hF7);
    tick(2);
    chk("unmasked line", 8'h00, {7'h00, l0_n});
    @(posedge clk) src <= 8'h08;
    wreg(SRC, 8'h08);
    src <= 8'h00;
    rreg(SRC, 8'h08, "set wins");
    wreg(MSK, 8'h00);
    $display("test mask done");
    prio(4'b0111, 3'b111, cia_pkg::VEC_POWER_FAIL, 2'd2);
    prio(4'b0110, 3'b000, cia_pkg::VEC_EXT_ZERO, 2'd0);
    prio(4'b0110, 3'b110, cia_pkg::VEC_EXT_ONE, 2'd1);
    prio(4'b0110, 3'b100, cia_pkg::VEC_WAKE, 2'd1);
    wreg(SRC, 8'h08);
    prio(4'b0100, 3'b000, cia_pkg::VEC_WAKE, 2'd0);
    chk("wake line", 8'h00, {7'h00, wk_n});
    prio(4'b0000, 3'b000, cia_pkg::VEC_NONE, 2'd0);
    chk("pending", 8'h00, {7'h00, pend});
    $display("test priority done");
    @(posedge clk) slp <= 1'b1;
    @(posedge clk) slp <= 1'b0;
    tick(2);
    chk("asleep", 8'h01, {7'h00, sleeping});
    @(posedge clk) grp <= 2'b10;
    tick(8);
    chk("restarts", 8'h01, rcount);
    chk("awake", 8'h00, {7'h00, sleeping});
    @(posedge clk) grp <= 2'b00;
    $display("test sleep done");
    results();
  end
endmodule
